/* sta_chk.sv */
// bound checker for the table access register ports
`timescale 1ns/10ps
module sta_chk #(
	parameter int INIT_CYC = 8
) (
	input wire logic              core_clk_i,
	input wire logic              rst_i,
	input wire sta_pkg::sta_bus_t bus_i,
	input wire logic [31:0]       rdata_o,
	input wire logic              make_start_i,
	input wire logic              drop_rx_o,
	input wire logic              age_tick_o,
	input wire logic              rx_tagged_i,
	input wire logic [11:0]       rx_vid_i,
	input wire logic              vlan_disable_i,
	input wire logic              pri_other_i,
	input wire logic [2:0]        pri_other_val_i,
	input wire logic [11:0]       eff_vid_o,
	input wire logic [2:0]        eff_pri_o
);
	import sta_pkg::*;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	chk_rd_idle: assert property (!$past(bus_i.rd) |-> rdata_o == ZERO32)
		else $error("read data not zero when idle");
	chk_init_flag: assert property ($past(bus_i.rd && bus_i.addr ==
		ADDR_STATUS) |-> rdata_o[1] == !$past(drop_rx_o))
		else $error("init flag disagrees with drop");
	chk_init_drop: assert property ($fell(rst_i) |->
		drop_rx_o [*4] ##[1:INIT_CYC] !drop_rx_o)
		else $error("init window wrong");
	chk_make_set: assert property ($past(bus_i.rd && bus_i.addr ==
		ADDR_STATUS) && $past(make_start_i, 2) |-> rdata_o[0])
		else $error("entry pending not set");
	chk_cfg_resv: assert property ($past(bus_i.rd && bus_i.addr ==
		ADDR_AGE_CFG) |-> rdata_o[31:1] == 31'h0)
		else $error("config reserved bits set");
	chk_tick_once: assert property (age_tick_o |=> !age_tick_o [*8])
		else $error("aging tick too long");
	chk_tag_vid: assert property (rx_tagged_i && rx_vid_i != 12'h0 &&
		!vlan_disable_i |-> eff_vid_o == rx_vid_i)
		else $error("tagged vid not kept");
	chk_pri_src: assert property (pri_other_i |->
		eff_pri_o == pri_other_val_i)
		else $error("other priority not used");
endmodule // sta_chk
bind sta_regs sta_chk #(.INIT_CYC(INIT_CYC)) u_chk (.*);

/* sta_pkg.sv */
// constants and types for the switch table access registers
// Contract
// RL1 - init-done status bit 1, self-sets
// RL2 - table init runs after every fabric reset
// RL3 - drop received packets while initialising
// RL4 - software polls init-done before table writes
// RL5 - entry-creation pending bit 0, self-clears
// RL6 - aging-test bit shortens aging to 50 ms
// RL7 - command write launches table access
// RL8 - pending bit marks read completion
// RL9 - software loads write data before command
// RL10 - command bit 5: 1 read, 0 write
// RL11 - command bit 4 selects port-default table
// RL12 - index 0-15 or port 0-2
// RL13 - port entry: vid 11:0, priority 14:12
// RL14 - untagged or null-vid packets get default vid
// RL15 - vlan disable forces default vid
// RL16 - default priority when no other source; reset 0
// RL17 - software avoids default vid 0 and FFFh
// RL18 - vlan select: 18-bit entry written whole
// RL19 - entry: member/untag per port, vid 11:0
// RL20 - dynamic entries age out after 5-10 min
// RL21 - pending raised on command, cleared on done
package sta_pkg;
	localparam logic [15:0] ADDR_STATUS   = 16'h1808;
	localparam logic [15:0] ADDR_AGE_CFG  = 16'h1809;
	localparam logic [15:0] ADDR_VLAN_CMD = 16'h180B;
	localparam logic [15:0] ADDR_VLAN_WR  = 16'h180C;
	localparam logic [15:0] ADDR_VLAN_CS  = 16'h180D;
	localparam logic [15:0] ADDR_VLAN_RD  = 16'h180E;
	localparam int BIT_INIT_DONE = 1;
	localparam int BIT_MAKE_PEND = 0;
	localparam int BIT_AGE_TEST  = 0;
	localparam int BIT_DIR       = 5;
	localparam int BIT_SEL       = 4;
	localparam int BIT_PEND      = 0;
	localparam int CMD_W         = 6;
	localparam int IDX_W         = 4;
	localparam int ENTRY_W       = 18;
	localparam int VID_W         = 12;
	localparam int PRI_W         = 3;
	localparam int PRI_LSB       = 12;
	localparam int VLAN_ENTRIES  = 16;
	localparam int NUM_PORTS     = 3;
	localparam int CLK_MHZ       = 40;
	localparam int INIT_TIME_US  = 20;
	localparam int INIT_CYCLES   = INIT_TIME_US * CLK_MHZ;
	localparam int AGE_TEST_MS   = 50;
	localparam int AGE_NORM_MIN  = 5;
	localparam longint AGE_TEST_CYC = longint'(AGE_TEST_MS) * 1000 * CLK_MHZ;
	localparam longint AGE_NORM_CYC =
		longint'(AGE_NORM_MIN) * 60 * 1000000 * CLK_MHZ;
	localparam logic [31:0] ZERO32 = 32'h0;

	typedef struct packed {
		logic [15:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} sta_bus_t;

	typedef struct packed {
		logic [PRI_W-1:0] pri;
		logic [VID_W-1:0] vlan_identifier;
	} sta_port_dflt_t;
endpackage

/* sta_regs.sv */
// register bank: table init status, aging test, vlan table access
`timescale 1ns/10ps
module sta_regs #(
	parameter longint AGE_NORM = sta_pkg::AGE_NORM_CYC,
	parameter longint AGE_TEST = sta_pkg::AGE_TEST_CYC,
	parameter int     INIT_CYC = sta_pkg::INIT_CYCLES
) (
	input  wire logic                 core_clk_i,
	input  wire logic                 rst_i,
	input  wire sta_pkg::sta_bus_t    bus_i,
	output logic [31:0]               rdata_o,
	input  wire logic                 make_start_i,
	input  wire logic                 make_done_i,
	output logic                      drop_rx_o,
	output logic                      age_tick_o,
	input  wire logic [1:0]           rx_port_i,
	input  wire logic                 rx_tagged_i,
	input  wire logic [11:0]          rx_vid_i,
	input  wire logic                 vlan_disable_i,
	input  wire logic                 pri_other_i,
	input  wire logic [2:0]           pri_other_val_i,
	output logic [11:0]               eff_vid_o,
	output logic [2:0]                eff_pri_o
);
	import sta_pkg::*;

	typedef enum logic [2:0] {
		ST_INIT = 3'h1,
		ST_IDLE = 3'h2,
		ST_BUSY = 3'h4
	} sta_state_t;

	sta_state_t              state, next_state;
	logic [15:0]             init_cnt, next_init_cnt;
	logic                    make_pend, next_make_pend;
	logic                    age_test, next_age_test;
	logic [CMD_W-1:0]        cmd, next_cmd;
	logic [ENTRY_W-1:0]      wdata, next_wdata;
	logic [ENTRY_W-1:0]      rd_data, next_rd_data;
	logic [ENTRY_W-1:0]      vlan_tab [VLAN_ENTRIES];
	logic [ENTRY_W-1:0]      next_vlan_tab [VLAN_ENTRIES];
	sta_port_dflt_t          port_tab [NUM_PORTS];
	sta_port_dflt_t          next_port_tab [NUM_PORTS];
	logic [31:0]             rdata, next_rdata;
	logic [39:0]             age_cnt, next_age_cnt;
	logic                    age_tick, next_age_tick;
	logic [39:0]             age_limit;
	logic [IDX_W-1:0]        idx;
	logic                    cmd_wr;
	logic                    cmd_take;
	logic                    port_ok;
	logic [1:0]              rx_sel;
	sta_port_dflt_t          rx_dflt;
	logic                    use_dflt_vid;

	// command register only opens while the engine is idle
	assign cmd_wr   = bus_i.wr && (bus_i.addr == ADDR_VLAN_CMD);
	assign cmd_take = cmd_wr && (state == ST_IDLE); // [RL7]
	assign idx      = cmd[IDX_W-1:0];
	assign port_ok  = (idx < IDX_W'(NUM_PORTS)); // [RL12]

	// init and access sequencing
	always_comb begin
		next_state    = state;
		next_init_cnt = init_cnt;
		case (state)
			ST_INIT: begin
				next_init_cnt = init_cnt + 16'h1; // [RL2]
				if (init_cnt >= 16'(INIT_CYC - 1)) begin
					next_state = ST_IDLE; // [RL1]
				end
			end
			ST_IDLE: begin
				if (cmd_take) begin
					next_state = ST_BUSY; // [RL21]
				end
			end
			ST_BUSY: begin
				// one-cycle access, so pending never stalls software
				next_state = ST_IDLE; // [RL21] [RL8]
			end
			default: begin
				next_state = ST_INIT;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state    <= ST_INIT; // [RL2]
			init_cnt <= 16'h0;
		end else begin
			state    <= next_state;
			init_cnt <= next_init_cnt;
		end
	end

	// entry-creation pending: start wins over done
	always_comb begin
		next_make_pend = make_pend;
		if (make_done_i) begin
			next_make_pend = 1'b0; // [RL5]
		end
		if (make_start_i) begin
			next_make_pend = 1'b1; // [RL5]
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			make_pend <= 1'b0;
		end else begin
			make_pend <= next_make_pend;
		end
	end

	// aging only ticks; entry removal lives outside this block
	assign age_limit = age_test ? AGE_TEST[39:0] : AGE_NORM[39:0]; // [RL6]

	always_comb begin
		next_age_cnt  = age_cnt + 40'h1;
		next_age_tick = 1'b0;
		if (age_cnt >= age_limit - 40'h1) begin
			next_age_cnt  = 40'h0; // [RL6] [RL20]
			next_age_tick = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			age_cnt  <= 40'h0;
			age_tick <= 1'b0;
		end else begin
			age_cnt  <= next_age_cnt;
			age_tick <= next_age_tick;
		end
	end

	// software-visible control registers
	always_comb begin
		next_age_test = age_test;
		next_cmd      = cmd;
		next_wdata    = wdata;
		if (bus_i.wr) begin
			case (bus_i.addr)
				ADDR_AGE_CFG: begin
					next_age_test = bus_i.wdata[BIT_AGE_TEST]; // [RL6]
				end
				ADDR_VLAN_WR: begin
					next_wdata = bus_i.wdata[ENTRY_W-1:0];
				end
				default: begin
					next_wdata = wdata;
				end
			endcase
		end
		// a command written while busy or initialising is dropped
		if (cmd_take) begin
			next_cmd = bus_i.wdata[CMD_W-1:0]; // [RL10] [RL11]
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			age_test <= 1'b0;
			cmd      <= '0;
			wdata    <= '0;
		end else begin
			age_test <= next_age_test;
			cmd      <= next_cmd;
			wdata    <= next_wdata;
		end
	end

	// table storage; init clears both tables
	always_comb begin
		next_vlan_tab = vlan_tab;
		next_port_tab = port_tab;
		next_rd_data  = rd_data;
		if (state == ST_INIT) begin
			for (int i = 0; i < VLAN_ENTRIES; i++) begin
				next_vlan_tab[i] = '0;
			end
			for (int i = 0; i < NUM_PORTS; i++) begin
				next_port_tab[i] = '0; // [RL16]
			end
		end
		if (state == ST_BUSY) begin
			if (cmd[BIT_SEL]) begin // [RL11]
				// bad port: write ignored, read keeps old data
				if (port_ok) begin // [RL12]
					if (cmd[BIT_DIR]) begin // [RL10]
						next_rd_data =
							ENTRY_W'(port_tab[idx[1:0]]);
					end else begin
						next_port_tab[idx[1:0]] =
							wdata[PRI_LSB+PRI_W-1:0]; // [RL13]
					end
				end
			end else begin
				if (cmd[BIT_DIR]) begin // [RL10]
					next_rd_data = vlan_tab[idx];
				end else begin
					next_vlan_tab[idx] = wdata; // [RL18] [RL19]
				end
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rd_data <= '0;
			for (int i = 0; i < VLAN_ENTRIES; i++) begin
				vlan_tab[i] <= '0;
			end
			for (int i = 0; i < NUM_PORTS; i++) begin
				port_tab[i] <= '0;
			end
		end else begin
			rd_data  <= next_rd_data;
			vlan_tab <= next_vlan_tab;
			port_tab <= next_port_tab;
		end
	end

	// read mux; unmapped numbers read zero
	always_comb begin
		next_rdata = ZERO32;
		if (bus_i.rd) begin
			case (bus_i.addr)
				ADDR_STATUS: begin
					next_rdata[BIT_INIT_DONE] =
						(state != ST_INIT); // [RL1]
					next_rdata[BIT_MAKE_PEND] = make_pend; // [RL5]
				end
				ADDR_AGE_CFG: begin
					next_rdata[BIT_AGE_TEST] = age_test;
				end
				ADDR_VLAN_CMD: begin
					next_rdata[CMD_W-1:0] = cmd;
				end
				ADDR_VLAN_WR: begin
					next_rdata[ENTRY_W-1:0] = wdata;
				end
				ADDR_VLAN_CS: begin
					next_rdata[BIT_PEND] =
						(state == ST_BUSY); // [RL8] [RL21]
				end
				ADDR_VLAN_RD: begin
					next_rdata[ENTRY_W-1:0] = rd_data;
				end
				default: begin
					next_rdata = ZERO32;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rdata <= ZERO32;
		end else begin
			rdata <= next_rdata;
		end
	end

	// classification is combinational: same-clock inputs, no pipeline
	assign rx_sel = (rx_port_i < 2'(NUM_PORTS)) ? rx_port_i : 2'h0;
	assign rx_dflt = port_tab[rx_sel];
	assign use_dflt_vid = vlan_disable_i || !rx_tagged_i
		|| (rx_vid_i == 12'h0); // [RL14] [RL15]
	assign eff_vid_o = use_dflt_vid ? rx_dflt.vlan_identifier : rx_vid_i;
	assign eff_pri_o = pri_other_i ? pri_other_val_i : rx_dflt.pri; // [RL16]
	assign drop_rx_o = (state == ST_INIT); // [RL3]
	assign rdata_o    = rdata;
	assign age_tick_o = age_tick;
endmodule // sta_regs

/* tb_top.sv */
// self-checking bench for the table access registers
`timescale 1ns/10ps
module tb_top;
	import sta_pkg::*;
	logic        clk = 0, rst = 1, ms = 0, md = 0, tg = 0, vd = 0, po = 0;
	sta_bus_t    bus = '0;
	logic [31:0] rd, s = 32'hF92209F8, d, ex [16];
	logic [11:0] vlan_identifier = '0, evid;
	logic [2:0]  pov = '0, epri;
	logic [1:0]  port = '0;
	logic        drop, tick;
	int          n_mismatch = 0, n_compared = 0, n_tick = 0;
	always #12.5 clk = ~clk;
	sta_regs #(.AGE_NORM(100), .AGE_TEST(10), .INIT_CYC(8)) uut (
		.core_clk_i(clk), .rst_i(rst), .bus_i(bus), .rdata_o(rd),
		.make_start_i(ms), .make_done_i(md), .drop_rx_o(drop),
		.age_tick_o(tick), .rx_port_i(port), .rx_tagged_i(tg),
		.rx_vid_i(vlan_identifier), .vlan_disable_i(vd), .pri_other_i(po),
		.pri_other_val_i(pov), .eff_vid_o(evid), .eff_pri_o(epri));
	function automatic logic [31:0] nx();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// untagged, null vid or vlan disabled fall back to the default
	function automatic logic [31:0] ev(logic [11:0] dv);
		return (!tg || vlan_identifier == 12'h0 || vd) ? 32'(dv) : 32'(vlan_identifier);
	endfunction
	task automatic chk(input logic [31:0] g, e);
		n_compared++;
		if (g !== e) begin
			$display("[ERR] %0t got %h exp %h", $time, g, e);
			n_mismatch++;
		end
	endtask
	task automatic acc(input logic [15:0] a, input logic [31:0] v,
		input logic w);
		@(posedge clk);
		bus <= '{a, v, w, !w};
		@(posedge clk);
		bus <= '{a, v, 1'b0, 1'b0};
		#1;
	endtask
	task automatic rchk(input logic [15:0] a, input logic [31:0] e);
		acc(a, 32'h0, 1'b0);
		chk(rd, e);
	endtask
	task automatic end_sim();
		if (n_mismatch == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		end_sim();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 0;
		rchk(ADDR_STATUS, 32'h0);
		rchk(ADDR_VLAN_CMD, 32'h0);
		chk(32'(drop), 32'h1);
		for (int w = 0; w < 20; w++) begin
			acc(ADDR_STATUS, 32'h0, 1'b0);
			if (rd[BIT_INIT_DONE] === 1'b1)
				break;
		end
		rchk(ADDR_STATUS, 32'h2);
		chk(32'(drop), 32'h0);
		rchk(16'h180A, 32'h0);
		acc(ADDR_AGE_CFG, 32'hFFFFFFFF, 1'b1);
		rchk(ADDR_AGE_CFG, 32'h1);
		@(posedge clk) ms <= 1;
		rchk(ADDR_STATUS, 32'h3);
		@(posedge clk) {ms, md} <= 2'b01;
		@(posedge clk) md <= 0;
		rchk(ADDR_STATUS, 32'h2);
		for (int i = 0; i < 16; i++) begin
			ex[i] = nx();
			acc(ADDR_VLAN_WR, ex[i], 1'b1);
			acc(ADDR_VLAN_CMD, 32'(i), 1'b1);
		end
		for (int i = 15; i >= 0; i--) begin
			acc(ADDR_VLAN_CMD, 32'h20 | 32'(i), 1'b1);
			rchk(ADDR_VLAN_RD, ex[i] & 32'h3FFFF);
		end
		// reserved write bits must not reach the port entry
		for (int p = 0; p < 3; p++) begin
			d = nx();
			if (d[11:0] == 12'h0 || d[11:0] == 12'hFFF) begin
				d[11:0] = 12'h5A5;
			end
			acc(ADDR_VLAN_WR, d, 1'b1);
			acc(ADDR_VLAN_CMD, 32'h10 | 32'(p), 1'b1);
			acc(ADDR_VLAN_CMD, 32'h30 | 32'(p), 1'b1);
			rchk(ADDR_VLAN_RD, d & 32'h7FFF);
			for (int k = 0; k < 8; k++) begin
				@(posedge clk);
				s = nx();
				{port, tg, vd, po, pov} <= {2'(p), s[2:0], s[5:3]};
				vlan_identifier <= s[17:6] & {12{s[18]}};
				#1;
				chk(32'(evid), ev(d[11:0]));
				chk(32'(epri), po ? 32'(pov) : 32'(d[14:12]));
			end
		end
		// back-to-back strobes catch the one-cycle pending bit
		@(posedge clk);
		bus <= '{ADDR_VLAN_CMD, 32'h20, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '{ADDR_VLAN_CS, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		#1;
		chk(rd, 32'h1);
		rchk(ADDR_VLAN_CS, 32'h0);
		// test aging period gives one tick every ten cycles here
		for (int k = 0; k < 40; k++) begin
			@(posedge clk);
			#1;
			n_tick += int'(tick);
		end
		chk(32'(n_tick), 32'h4);
		end_sim();
	end
endmodule // tb_top
